// [design/bbmc_pkg.sv]
// constants shared by the boost and buck mode control block
//------------------------------------------------------------
//------------------------------------------------------------
package bbmc_pkg;

   // -----------------------------------------------------------
   // clock and timing
   // -----------------------------------------------------------
   localparam int unsigned CLK_MHZ       = 125;
   localparam int unsigned LAG_LONG_MS   = 1;
   localparam int unsigned LAG_SHORT_US  = 100;
   localparam int unsigned LAG_LONG_CYC  = LAG_LONG_MS * 1000 * CLK_MHZ;
   localparam int unsigned LAG_SHORT_CYC = LAG_SHORT_US * CLK_MHZ;
   localparam int unsigned LAG_W         = 17;
   localparam int unsigned PHASE_NS      = 40;
   localparam int unsigned PHASE_CYC     = (PHASE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned BST_PERIOD_NS = 2000;
   localparam int unsigned BST_PERIOD    = (BST_PERIOD_NS * CLK_MHZ) / 1000;
   localparam int unsigned PWM_W         = 8;
   localparam int unsigned DUTY_MAX      = 150;
   localparam int unsigned DUTY_MIN      = 40;
   localparam int unsigned DUTY_STEP     = 16;

   // -----------------------------------------------------------
   // register map
   // -----------------------------------------------------------
   localparam logic [7:0] OFF_MODE   = 8'h00;
   localparam logic [7:0] OFF_HWCTL  = 8'h04;
   localparam logic [7:0] OFF_REGST  = 8'h08;
   localparam logic [7:0] OFF_WAKEST = 8'h0C;
   localparam logic [7:0] OFF_LIVE   = 8'h10;

   // mode field values
   localparam logic [2:0] MODE_NORMAL   = 3'h0;
   localparam logic [2:0] MODE_STOP     = 3'h1;
   localparam logic [2:0] MODE_RESTART  = 3'h2;
   localparam logic [2:0] MODE_SLEEP    = 3'h3;
   localparam logic [2:0] MODE_FAILSAFE = 3'h4;
   localparam logic [2:0] MODE_RST      = MODE_NORMAL;

   // hardware control bits
   localparam int unsigned HW_BOOST_EN  = 0;
   localparam int unsigned HW_LEVEL_SEL = 1;
   localparam int unsigned HW_AUTO_EN   = 2;
   localparam int unsigned HW_LAG_SEL   = 3;
   localparam logic [3:0]  HW_RST       = 4'h4;

   // regulator status bits
   localparam int unsigned ST_GSH_GND  = 0;
   localparam int unsigned ST_GSH_SUP  = 1;
   localparam int unsigned ST_ACTIVE   = 2;
   localparam int unsigned ST_OVERCUR  = 3;
   localparam int unsigned ST_PINFAULT = 4;

   // wake status bit
   localparam int unsigned WK_LLEXIT = 0;

   // synchronised comparator positions
   localparam int unsigned NCMP        = 8;
   localparam int unsigned C_BELOW_LO  = 0;
   localparam int unsigned C_ABOVE_LO  = 1;
   localparam int unsigned C_BELOW_HI  = 2;
   localparam int unsigned C_ABOVE_HI  = 3;
   localparam int unsigned C_LOAD      = 4;
   localparam int unsigned C_OVERCUR   = 5;
   localparam int unsigned C_GATE_HIGH = 6;
   localparam int unsigned C_PINFAULT  = 7;

   typedef enum logic [2:0] {PH0, PH1, PH2, PH3, PH4, PH5, PH6, PH7} bbmc_phase_e;

endpackage

// [design/bbmc_sync.sv]
// two-stage synchroniser for comparator outputs
`timescale 1ns/1ns
module bbmc_sync #(
   parameter int unsigned W = 8
) (
   input  wire logic         clk_i,
   input  wire logic         reset_n_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_q;

   //------------------------------------------------------------
   // per bit two flops
   //------------------------------------------------------------
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            meta_q[i] <= 1'b0;
            sync_o[i] <= 1'b0;
         end else begin
            meta_q[i] <= async_i[i];
            sync_o[i] <= meta_q[i];
         end
      end
   end

endmodule // bbmc_sync

// [design/bbmc_top.sv]
// boost and buck mode control with AHB-Lite register slave
`timescale 1ns/1ns
module bbmc_top #(
   parameter int unsigned LAG_LONG_CYC  = bbmc_pkg::LAG_LONG_CYC,
   parameter int unsigned LAG_SHORT_CYC = bbmc_pkg::LAG_SHORT_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // analog comparators
   input  wire logic        sense_below_low_th_i,
   input  wire logic        sense_above_low_hys_i,
   input  wire logic        sense_below_high_th_i,
   input  wire logic        sense_above_high_hys_i,
   input  wire logic        load_above_th_i,
   input  wire logic        peak_overcurrent_i,
   input  wire logic        gate_above_short_th_i,
   input  wire logic        boost_pin_fault_i,
   // power stage controls
   output logic             gate_charge_o,
   output logic             gate_pullup_o,
   output logic             gate_discharge_o,
   output logic             gate_pulldown_o,
   output logic             boost_switching_o,
   output logic             buck_enable_o,
   output logic             buck_pwm_o,
   output logic             event_o
);

   //------------------------------------------------------------
   // comparator synchronisation
   //------------------------------------------------------------
   logic [bbmc_pkg::NCMP-1:0] cmp_raw;
   logic [bbmc_pkg::NCMP-1:0] cmp;

   assign cmp_raw = {boost_pin_fault_i, gate_above_short_th_i, peak_overcurrent_i, load_above_th_i,
                     sense_above_high_hys_i, sense_below_high_th_i, sense_above_low_hys_i,
                     sense_below_low_th_i};

   bbmc_sync #(
      .W (bbmc_pkg::NCMP)
   ) u_sync (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (cmp_raw),
      .sync_o    (cmp)
   );

   //------------------------------------------------------------
   // bus address phase capture
   //------------------------------------------------------------
   logic       wr_pend_q;
   logic [7:0] wr_addr_q;
   logic       acc;

   assign acc = hsel_i && hready_i && htrans_i[1];

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= acc && hwrite_i;
         if (acc) begin
            wr_addr_q <= haddr_i[7:0];
         end
      end
   end

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   logic wr_mode;
   logic wr_hw;
   logic wr_rst;
   logic wr_wk;
   logic stop_cmd;

   assign wr_mode  = wr_pend_q && hit(wr_addr_q, bbmc_pkg::OFF_MODE);
   assign wr_hw    = wr_pend_q && hit(wr_addr_q, bbmc_pkg::OFF_HWCTL);
   assign wr_rst   = wr_pend_q && hit(wr_addr_q, bbmc_pkg::OFF_REGST);
   assign wr_wk    = wr_pend_q && hit(wr_addr_q, bbmc_pkg::OFF_WAKEST);
   assign stop_cmd = wr_mode && (hwdata_i[2:0] == bbmc_pkg::MODE_STOP);

   //------------------------------------------------------------
   // mode and hardware control registers
   //------------------------------------------------------------
   logic [2:0] mode_q;
   logic [3:0] hw_q;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_q <= bbmc_pkg::MODE_RST;
      end else if (wr_mode) begin
         mode_q <= hwdata_i[2:0];
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hw_q <= bbmc_pkg::HW_RST;
      end else if (wr_hw) begin
         hw_q <= hwdata_i[3:0];
      end
   end

   logic reg_on;
   logic in_stop;
   logic boost_run;
   logic below_sel;
   logic above_sel;

   assign reg_on    = (mode_q == bbmc_pkg::MODE_NORMAL) || (mode_q == bbmc_pkg::MODE_STOP) ||
                      (mode_q == bbmc_pkg::MODE_RESTART);
   assign in_stop   = (mode_q == bbmc_pkg::MODE_STOP);
   assign boost_run = reg_on && hw_q[bbmc_pkg::HW_BOOST_EN];
   assign below_sel = hw_q[bbmc_pkg::HW_LEVEL_SEL] ? cmp[bbmc_pkg::C_BELOW_LO]
                                                   : cmp[bbmc_pkg::C_BELOW_HI];
   assign above_sel = hw_q[bbmc_pkg::HW_LEVEL_SEL] ? cmp[bbmc_pkg::C_ABOVE_LO]
                                                   : cmp[bbmc_pkg::C_ABOVE_HI];

   //------------------------------------------------------------
   // hysteretic boost switching
   //------------------------------------------------------------
   logic sw_q;
   logic boost_start;

   assign boost_start = boost_run && !sw_q && below_sel;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sw_q <= 1'b0;
      end else if (!boost_run) begin
         sw_q <= 1'b0;
      end else if (boost_start) begin
         sw_q <= 1'b1;
      end else if (sw_q && above_sel) begin
         sw_q <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // fixed-frequency period and duty
   //------------------------------------------------------------
   logic [bbmc_pkg::PWM_W-1:0] cnt_q;
   logic [bbmc_pkg::PWM_W-1:0] duty_q;
   logic                       oc_seen_q;
   logic                       cyc_start;

   assign cyc_start = sw_q && (cnt_q == '0);

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_q <= '0;
      end else if (!sw_q || (cnt_q == bbmc_pkg::PWM_W'(bbmc_pkg::BST_PERIOD - 1))) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         oc_seen_q <= 1'b0;
      end else if (cyc_start) begin
         oc_seen_q <= cmp[bbmc_pkg::C_OVERCUR];
      end else if (cmp[bbmc_pkg::C_OVERCUR]) begin
         oc_seen_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         duty_q <= bbmc_pkg::PWM_W'(bbmc_pkg::DUTY_MAX);
      end else if (cyc_start) begin
         if (oc_seen_q) begin
            if (duty_q > bbmc_pkg::PWM_W'(bbmc_pkg::DUTY_MIN + bbmc_pkg::DUTY_STEP)) begin
               duty_q <= duty_q - bbmc_pkg::PWM_W'(bbmc_pkg::DUTY_STEP);
            end else begin
               duty_q <= bbmc_pkg::PWM_W'(bbmc_pkg::DUTY_MIN);
            end
         end else if (duty_q < bbmc_pkg::PWM_W'(bbmc_pkg::DUTY_MAX)) begin
            duty_q <= duty_q + 1'b1;
         end
      end
   end

   //------------------------------------------------------------
   // gate driver phases
   //------------------------------------------------------------
   bbmc_pkg::bbmc_phase_e ph_q;
   logic [3:0]            ph_cnt_q;
   logic                  kill_q;
   logic                  ph_done;
   logic                  short_gnd;
   logic                  short_sup;

   assign ph_done   = (ph_cnt_q == 4'(bbmc_pkg::PHASE_CYC - 1));
   assign short_gnd = (ph_q == bbmc_pkg::PH4) && !kill_q && !cmp[bbmc_pkg::C_GATE_HIGH];
   assign short_sup = (ph_q == bbmc_pkg::PH0) && !kill_q && sw_q &&
                      cmp[bbmc_pkg::C_GATE_HIGH];

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ph_q     <= bbmc_pkg::PH0;
         ph_cnt_q <= 4'h0;
         kill_q   <= 1'b0;
      end else if (!sw_q) begin
         ph_q     <= bbmc_pkg::PH0;
         ph_cnt_q <= 4'h0;
         kill_q   <= 1'b0;
      end else if (cyc_start) begin
         ph_q     <= bbmc_pkg::PH1;
         ph_cnt_q <= 4'h0;
         kill_q   <= 1'b0;
      end else if (short_gnd || short_sup) begin
         ph_q     <= bbmc_pkg::PH0;
         kill_q   <= 1'b1;
      end else begin
         ph_cnt_q <= ph_done ? 4'h0 : ph_cnt_q + 1'b1;
         case (ph_q)
            bbmc_pkg::PH1, bbmc_pkg::PH2, bbmc_pkg::PH3, bbmc_pkg::PH5, bbmc_pkg::PH6: begin
               if (ph_done) begin
                  ph_q <= bbmc_pkg::bbmc_phase_e'(ph_q + 3'h1);
               end
            end
            bbmc_pkg::PH4: begin
               if (cnt_q >= duty_q) begin
                  ph_q <= bbmc_pkg::PH5;
               end
            end
            bbmc_pkg::PH7: begin
               if (ph_done) begin
                  ph_q <= bbmc_pkg::PH0;
               end
            end
            default: begin
               ph_q <= bbmc_pkg::PH0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gate_charge_o    <= 1'b0;
         gate_pullup_o    <= 1'b0;
         gate_discharge_o <= 1'b0;
         gate_pulldown_o  <= 1'b1;
      end else begin
         gate_charge_o    <= !kill_q && ((ph_q == bbmc_pkg::PH1) || (ph_q == bbmc_pkg::PH2));
         gate_pullup_o    <= !kill_q && ((ph_q == bbmc_pkg::PH3) || (ph_q == bbmc_pkg::PH4));
         gate_discharge_o <= !kill_q && ((ph_q == bbmc_pkg::PH5) || (ph_q == bbmc_pkg::PH6));
         gate_pulldown_o  <= !kill_q && ((ph_q == bbmc_pkg::PH7) || (ph_q == bbmc_pkg::PH0));
      end
   end

   //------------------------------------------------------------
   // regulator status flags
   //------------------------------------------------------------
   logic [4:0] st_q;
   logic [4:0] st_set;
   logic [4:0] st_clr;

   always_comb begin
      st_set                         = '0;
      st_set[bbmc_pkg::ST_GSH_GND]   = short_gnd;
      st_set[bbmc_pkg::ST_GSH_SUP]   = short_sup;
      st_set[bbmc_pkg::ST_ACTIVE]    = boost_start;
      st_set[bbmc_pkg::ST_OVERCUR]   = sw_q && cmp[bbmc_pkg::C_OVERCUR];
      st_set[bbmc_pkg::ST_PINFAULT]  = cmp[bbmc_pkg::C_PINFAULT];
      st_clr                         = wr_rst ? hwdata_i[4:0] : 5'h00;
      st_clr[bbmc_pkg::ST_ACTIVE]    = st_clr[bbmc_pkg::ST_ACTIVE] && !below_sel;
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= 5'h00;
      end else begin
         st_q <= (st_q & ~st_clr) | st_set;
      end
   end

   //------------------------------------------------------------
   // buck modulation control
   //------------------------------------------------------------
   logic                   pwm_q;
   logic                   lag_run_q;
   logic                   armed_q;
   logic                   llx_q;
   logic [bbmc_pkg::LAG_W-1:0] lag_q;
   logic                   auto_up;

   assign auto_up = in_stop && !lag_run_q && armed_q && hw_q[bbmc_pkg::HW_AUTO_EN] &&
                    !pwm_q && cmp[bbmc_pkg::C_LOAD];

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pwm_q     <= 1'b1;
         lag_run_q <= 1'b0;
         armed_q   <= 1'b0;
         lag_q     <= '0;
      end else if (stop_cmd) begin
         lag_run_q <= 1'b1;
         armed_q   <= 1'b0;
         lag_q     <= hw_q[bbmc_pkg::HW_LAG_SEL] ? bbmc_pkg::LAG_W'(LAG_LONG_CYC - 1)
                                                 : bbmc_pkg::LAG_W'(LAG_SHORT_CYC - 1);
      end else if (!in_stop) begin
         pwm_q     <= 1'b1;
         lag_run_q <= 1'b0;
         armed_q   <= 1'b0;
      end else if (lag_run_q) begin
         if (lag_q == '0) begin
            lag_run_q <= 1'b0;
            pwm_q     <= 1'b0;
            armed_q   <= 1'b1;
         end else begin
            lag_q <= lag_q - 1'b1;
         end
      end else if (auto_up) begin
         pwm_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         llx_q   <= 1'b0;
         event_o <= 1'b0;
      end else begin
         event_o <= auto_up;
         if (auto_up) begin
            llx_q <= 1'b1;
         end else if (wr_wk && hwdata_i[bbmc_pkg::WK_LLEXIT]) begin
            llx_q <= 1'b0;
         end
      end
   end

   //------------------------------------------------------------
   // power stage outputs
   //------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         boost_switching_o <= 1'b0;
         buck_enable_o     <= 1'b0;
         buck_pwm_o        <= 1'b1;
      end else begin
         boost_switching_o <= sw_q;
         buck_enable_o     <= reg_on;
         buck_pwm_o        <= pwm_q;
      end
   end

   //------------------------------------------------------------
   // read data and response
   //------------------------------------------------------------
   function automatic logic [31:0] rd_mux(input logic [7:0] a);
      rd_mux = 32'h0000_0000;
      case (a)
         bbmc_pkg::OFF_MODE:   rd_mux[2:0] = mode_q;
         bbmc_pkg::OFF_HWCTL:  rd_mux[3:0] = hw_q;
         bbmc_pkg::OFF_REGST:  rd_mux[4:0] = st_q;
         bbmc_pkg::OFF_WAKEST: rd_mux[0]   = llx_q;
         bbmc_pkg::OFF_LIVE:   rd_mux[8:0] = {ph_q, 1'b0, armed_q, lag_run_q, reg_on, sw_q, pwm_q};
         default:              rd_mux      = 32'h0000_0000;
      endcase
   endfunction

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hrdata_o    <= 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
         if (acc && !hwrite_i) begin
            hrdata_o <= rd_mux(haddr_i[7:0]);
         end
      end
   end

   logic unused_ok;
   assign unused_ok = ^{haddr_i[31:8], hsize_i, htrans_i[0], hwdata_i[31:5]};

endmodule // bbmc_top

// [test/bbmc_checker.sv]
// assertion checker for the boost and buck mode control block
`timescale 1ns/1ns
module bbmc_checker (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic load_above_th_i,
   input wire logic gate_above_short_th_i,
   input wire logic gate_charge_o,
   input wire logic gate_pullup_o,
   input wire logic gate_discharge_o,
   input wire logic gate_pulldown_o,
   input wire logic boost_switching_o,
   input wire logic buck_enable_o,
   input wire logic buck_pwm_o,
   input wire logic event_o
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   a_event_rise:
      assert property (event_o |=> buck_pwm_o && !$past(buck_pwm_o)) else $error("event without pwm rise");
   a_event_pulse:
      assert property (event_o |=> !event_o) else $error("event longer than one cycle");
   a_event_load:
      assert property (event_o |-> $past(load_above_th_i, 3)) else $error("event without load");
   a_gate_onehot:
      assert property ($onehot0({gate_charge_o, gate_pullup_o, gate_discharge_o, gate_pulldown_o}))
         else $error("gate phases overlap");
   a_pullup_order:
      assert property ($rose(gate_pullup_o) |-> $past(gate_charge_o)) else $error("pullup not after charge");
   a_charge_blank:
      assert property (gate_charge_o && boost_switching_o |=> gate_charge_o || gate_pullup_o || !boost_switching_o)
         else $error("charge cut short");
   a_gnd_kill:
      assert property ((gate_pullup_o && !gate_above_short_th_i) [*8] |-> ##[1:4] !gate_pullup_o)
         else $error("ground short not cut");
   a_sup_kill:
      assert property ((gate_pulldown_o && gate_above_short_th_i && boost_switching_o) [*8] |-> ##[1:4] !gate_pulldown_o)
         else $error("supply short not cut");
   a_off_boost:
      assert property (!buck_enable_o [*3] |-> !boost_switching_o) else $error("boost runs while off");
   a_pwm_lag:
      assert property ($fell(buck_pwm_o) |-> $past(buck_pwm_o, 8)) else $error("pfm without lag");
   c_event: cover property (event_o);
   c_kill: cover property ($fell(gate_pullup_o) && !gate_discharge_o);
   c_pfm: cover property ($fell(buck_pwm_o));
endmodule // bbmc_checker

bind bbmc_top bbmc_checker i_bbmc_checker (.clk_i, .reset_n_i, .load_above_th_i, .gate_above_short_th_i,
   .gate_charge_o, .gate_pullup_o, .gate_discharge_o, .gate_pulldown_o, .boost_switching_o, .buck_enable_o,
   .buck_pwm_o, .event_o);

// [test/bbmc_stage_model.sv]
// gate pin and boost switch model with injectable shorts
`timescale 1ns/1ns
module bbmc_stage_model (
   input  wire logic gate_charge_i,
   input  wire logic gate_pullup_i,
   input  wire logic gate_discharge_i,
   input  wire logic gate_pulldown_i,
   input  wire logic clk_i,
   input  wire logic short_gnd_i,
   input  wire logic short_sup_i,
   output logic      gate_above_short_th_o
);
   logic float_q = 1'b0;
   always_ff @(posedge clk_i) float_q <= ~float_q;
   always_comb begin
      if (short_gnd_i) gate_above_short_th_o = 1'b0;
      else if (short_sup_i) gate_above_short_th_o = 1'b1;
      else if (gate_charge_i || gate_pullup_i) gate_above_short_th_o = 1'b1;
      else if (gate_discharge_i || gate_pulldown_i) gate_above_short_th_o = 1'b0;
      else gate_above_short_th_o = float_q;
   end
endmodule // bbmc_stage_model

// [test/bbmc_top_tb.sv]
// self-checking testbench for the boost and buck mode control block
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("mismatch %s exp %h seen %h", n, e, g); end end
module bbmc_top_tb;
   localparam int LAGS = 8;
   localparam int LAGL = 20;
   logic clk_i = 0, reset_n_i = 0, hsel = 0, hwrite = 0, hrdy, load = 0, ocur = 0, pinf = 0, sgnd = 0, ssup = 0;
   logic [1:0] htrans = 0;
   logic [7:0] haddr = 0;
   logic [31:0] hwdata = 0, hrdata, rd;
   logic [3:0] sense = 0;
   logic gch, gpu, gdc, gpd, gcmp, bsw, ben, bpwm, ev;
   int err_total = 0, n_tests = 0, cyc = 0, ev_cnt = 0, pu_cnt = 0, p0, p1;
   bbmc_top #(.LAG_LONG_CYC(LAGL), .LAG_SHORT_CYC(LAGS)) i_bbmc_top (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .hsel_i(hsel), .haddr_i({24'h0, haddr}), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(),
      .sense_below_low_th_i(sense[0]), .sense_above_low_hys_i(sense[1]), .sense_below_high_th_i(sense[2]),
      .sense_above_high_hys_i(sense[3]), .load_above_th_i(load), .peak_overcurrent_i(ocur),
      .gate_above_short_th_i(gcmp), .boost_pin_fault_i(pinf), .gate_charge_o(gch), .gate_pullup_o(gpu),
      .gate_discharge_o(gdc), .gate_pulldown_o(gpd), .boost_switching_o(bsw), .buck_enable_o(ben),
      .buck_pwm_o(bpwm), .event_o(ev));
   bbmc_stage_model i_bbmc_stage_model (.gate_charge_i(gch), .gate_pullup_i(gpu), .gate_discharge_i(gdc),
      .gate_pulldown_i(gpd), .clk_i(clk_i), .short_gnd_i(sgnd), .short_sup_i(ssup), .gate_above_short_th_o(gcmp));
   // ------------------------------------------------------------
   // clock, monitor and tasks
   // ------------------------------------------------------------
   initial forever #4 clk_i = ~clk_i;
   always @(negedge clk_i) begin
      cyc++;
      if (ev === 1'b1) ev_cnt++;
      if (gpu === 1'b1) pu_cnt++;
      if (cyc > 20000) begin
         err_total++;
         complete_run();
      end
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
      do @(posedge clk_i); while (hrdy !== 1'b1);
      htrans <= 2'h0; hwdata <= wd;
      do @(posedge clk_i); while (hrdy !== 1'b1);
      rd = hrdata;
      if (w) @(posedge clk_i);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
      xfer(1'b0, a, 32'h0);
      `CHK(n, e, rd)
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk_i);
      reset_n_i <= 1'b1;
      wt(1);
      rdchk(8'h00, 32'h0, "mode"); rdchk(8'h04, 32'h4, "hwctl"); rdchk(8'h0C, 32'h0, "wake");
      rdchk(8'h08, 32'h0, "status"); xfer(1'b1, 8'h20, 32'hFFFFFFFF); rdchk(8'h20, 32'h0, "unmapped");
      $display("test registers done");
      for (int s = 0; s < 2; s++) begin
         xfer(1'b1, 8'h00, 32'h0); wt(2);
         `CHK("pwm normal", 1'b1, bpwm)
         xfer(1'b1, 8'h04, {28'h0, s[0], 3'h4}); xfer(1'b1, 8'h00, 32'h1);
         wt((s ? LAGL : LAGS) - 1);
         `CHK("pwm in lag", 1'b1, bpwm)
         wt(6);
         `CHK("pwm stop", 1'b0, bpwm)
      end
      $display("test lag done");
      xfer(1'b1, 8'h04, 32'h4); xfer(1'b1, 8'h00, 32'h1); wt(LAGS + 4); ev_cnt = 0; load <= 1'b1; wt(8);
      `CHK("pwm auto", 1'b1, bpwm)
      `CHK("events", 1, ev_cnt)
      rdchk(8'h0C, 32'h1, "light exit");
      load <= 1'b0; xfer(1'b1, 8'h0C, 32'h1); rdchk(8'h0C, 32'h0, "light clear");
      xfer(1'b1, 8'h00, 32'h1); wt(LAGS + 4);
      `CHK("pwm back", 1'b0, bpwm)
      xfer(1'b1, 8'h04, 32'h0); xfer(1'b1, 8'h00, 32'h1); wt(LAGS + 4); load <= 1'b1; wt(10);
      `CHK("pwm no auto", 1'b0, bpwm)
      `CHK("no event", 1, ev_cnt)
      load <= 1'b0;
      $display("test buck done");
      for (int m = 2; m < 5; m++) begin
         xfer(1'b1, 8'h00, m); wt(3);
         `CHK("regulator on", m == 2, ben)
      end
      xfer(1'b1, 8'h00, 32'h0);
      for (int s = 0; s < 2; s++) begin
         xfer(1'b1, 8'h04, {30'h0, s[0], 1'b1}); sense <= s ? 4'h4 : 4'h1; wt(10);
         `CHK("other level", 1'b0, bsw)
         sense <= s ? 4'h1 : 4'h4; wt(10);
         `CHK("boost on", 1'b1, bsw)
         rdchk(8'h08, 32'h4, "active"); xfer(1'b1, 8'h08, 32'h4); rdchk(8'h08, 32'h4, "active held");
         sense <= s ? 4'h2 : 4'h8; wt(10);
         `CHK("boost off", 1'b0, bsw)
         xfer(1'b1, 8'h08, 32'h4); rdchk(8'h08, 32'h0, "active clear");
      end
      xfer(1'b1, 8'h00, 32'h1); sense <= 4'h1; wt(10);
      `CHK("boost stop mode", 1'b1, bsw)
      xfer(1'b1, 8'h04, 32'h2); wt(10);
      `CHK("boost disabled", 1'b0, bsw)
      xfer(1'b1, 8'h04, 32'h3); xfer(1'b1, 8'h00, 32'h0); wt(300);
      p0 = pu_cnt; wt(250); p0 = pu_cnt - p0; ocur <= 1'b1; wt(2000); p1 = pu_cnt; wt(250); p1 = pu_cnt - p1;
      `CHK("duty cut", 1'b1, p1 < p0)
      ocur <= 1'b0; wt(4); xfer(1'b1, 8'h08, 32'h1F); sgnd <= 1'b1; wt(300);
      rdchk(8'h08, 32'h5, "short ground");
      sgnd <= 1'b0; wt(4); xfer(1'b1, 8'h08, 32'h1F); ssup <= 1'b1; wt(300);
      rdchk(8'h08, 32'h6, "short supply");
      ssup <= 1'b0; wt(4); xfer(1'b1, 8'h08, 32'h1F); pinf <= 1'b1; wt(5);
      rdchk(8'h08, 32'h14, "pin fault");
      rdchk(8'h00, 32'h0, "mode kept");
      `CHK("still on", 1'b1, ben)
      $display("test boost done");
      complete_run();
   end
endmodule // bbmc_top_tb
